// ==== hw/amsc_pkg.sv ====
// Constants, types and timing for the four-channel converter control link.
// Assumes a single 250 MHz system clock on both ends of the link.
//
// Behaviour
// - Old result readable until 12 us after start; internal clock here reloads the shifter at start
// - Host never reads from 12 us to busy
// - Host avoids external clocking during conversions
// - Daisy input sampled on active data clock
// - External clock: daisy bits follow LSB until reload
// - Internal clock: first-edge daisy level after 12 bits
// - Continuous mode converts repeatedly while controls low
// - Continuous starts at channel after last loaded
// - Continuous mode drives both address pins
// - Busy rise increments channel, drives next address
// - Power-down pulse resets channel address to zero
// - After channel reset first conversion uses channel 0
// - Channels ascend, wrap to zero after three
// - Manual start latches pins for next conversion
// - Manual mode ignores starts while converting
// - Start edges convert previously latched channel
// - Continuous start edges restart on next channel; device end here ignores start edges while converting in both modes
// - Power-down during conversion gives meaningless data
// - Continuous power-down high selects channel zero next
// - Host waits recharge time before continuous mode
// - Host waits acquisition time after short power-down; host end here delays only continuous mode, by SETTLE, not manual starts
// - Busy low at start, high when result stored
// - Manual address bits form binary channel index
package amsc_pkg;
  localparam int RES_W  = 12;
  localparam int CHAN_W = 2;
  localparam int CNT_W  = 12;
  localparam int PH_W   = 9;
  localparam int BIT_W  = 4;
  localparam logic [CHAN_W-1:0] CHAN_ZERO = 2'h0;
  localparam logic [CHAN_W-1:0] CHAN_LAST = 2'h3;
  localparam logic [CHAN_W-1:0] CHAN_STEP = 2'h1;

  // Times in their own units
  localparam int CLK_NS     = 4;
  localparam int CONV_NS    = 15000;
  localparam int KEEP_NS    = 12000;
  localparam int INT_DLY_NS = 1400;
  localparam int INT_PER_NS = 1100;
  localparam int EXT_PER_NS = 160;
  localparam int PD_NS      = 200;
  localparam int RC_LOW_NS  = 40;
  localparam int SETTLE_NS  = 1000000;

  // Cycle counts; least times round up
  localparam logic [CNT_W-1:0] CONV_CYC    = CNT_W'(CONV_NS / CLK_NS);
  localparam logic [CNT_W-1:0] INT_DLY_CYC = CNT_W'(INT_DLY_NS / CLK_NS);
  localparam logic [PH_W-1:0]  INT_PER_CYC = PH_W'(INT_PER_NS / CLK_NS);
  localparam logic [PH_W-1:0]  INT_HALF    = PH_W'(INT_PER_NS / (2 * CLK_NS));
  localparam logic [PH_W-1:0]  EXT_PER_CYC = PH_W'(EXT_PER_NS / CLK_NS);
  localparam logic [PH_W-1:0]  EXT_HALF    = PH_W'(EXT_PER_NS / (2 * CLK_NS));
  localparam logic [PH_W-1:0]  PD_CYC      = PH_W'((PD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [PH_W-1:0]  RC_LOW_CYC  = PH_W'((RC_LOW_NS + CLK_NS - 1) / CLK_NS);
  localparam int               SETTLE_CYC  = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int               SET_W       = 18;
  localparam logic [BIT_W-1:0] BITS_DONE   = BIT_W'(RES_W);
  localparam logic [BIT_W-1:0] BITS_STOP   = BIT_W'(RES_W + 1);

  // Synchroniser lanes on the device end
  localparam int DS_CS = 0;
  localparam int DS_RC = 1;
  localparam int DS_PD = 2;
  localparam int DS_CM = 3;
  localparam int DS_EX = 4;
  localparam int DS_DK = 5;
  localparam int DS_TG = 6;
  localparam int DS_A0 = 7;
  localparam int DS_A1 = 8;
  localparam int DS_W  = 9;

  typedef enum logic [0:0] {CV_IDLE, CV_RUN} amsc_conv_t;
  typedef enum logic [2:0] {H_IDLE, H_CONV, H_WAITLO, H_WAITHI, H_READ, H_PD} amsc_host_t;
endpackage

// ==== hw/amsc_link_if.sv ====
// Pin-level link between the converter control end and its host controller.
// Assumes both ends drive outputs plus enables; wire levels resolved here.
`timescale 1ns/10ps
interface amsc_link_if;
  logic cs_n;
  logic rd_conv;
  logic power_down;
  logic continuous_mode_select;
  logic ext_clock_select;
  logic data_shift_clock;
  logic daisy_in;
  logic busy_n;
  logic int_data_clock;
  logic serial_out_drv;
  logic serial_out_oe;
  logic serial_out;
  logic [1:0] host_addr_out;
  logic [1:0] host_addr_oe;
  logic [1:0] dev_addr_out;
  logic [1:0] dev_addr_oe;
  logic chan_addr_bit0;
  logic chan_addr_bit1;

  // Undriven wires read low; device drive wins a clash
  assign serial_out     = serial_out_oe ? serial_out_drv : 1'b0;
  assign chan_addr_bit0 = dev_addr_oe[0] ? dev_addr_out[0] : (host_addr_oe[0] & host_addr_out[0]);
  assign chan_addr_bit1 = dev_addr_oe[1] ? dev_addr_out[1] : (host_addr_oe[1] & host_addr_out[1]);

  modport dev (
    input  cs_n, rd_conv, power_down, continuous_mode_select, ext_clock_select,
    input  data_shift_clock, daisy_in, chan_addr_bit0, chan_addr_bit1,
    output busy_n, int_data_clock, serial_out_drv, serial_out_oe, dev_addr_out, dev_addr_oe
  );
  modport host (
    output cs_n, rd_conv, power_down, continuous_mode_select, ext_clock_select,
    output data_shift_clock, daisy_in, host_addr_out, host_addr_oe,
    input  busy_n, serial_out, chan_addr_bit0, chan_addr_bit1
  );
endinterface // amsc_link_if

// ==== hw/amsc_sync.sv ====
// Two-flop synchroniser for a vector of independent levels.
// Assumes each lane is a slow level; no word coherence across lanes.
`timescale 1ns/10ps
module amsc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  // First stage feeds only the second
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule // amsc_sync

// ==== hw/amsc_dev_end.sv ====
// Converter end: start decode, channel sequencing, busy, serial read-out.
// Assumes link pins are asynchronous; every one is synchronised first.
`timescale 1ns/10ps
module amsc_dev_end (
  input  wire logic                         clk,
  input  wire logic                         reset_n,
  amsc_link_if.dev                          lnk,
  input  wire logic [amsc_pkg::RES_W-1:0]   sample_value,
  output logic      [amsc_pkg::CHAN_W-1:0]  conv_chan,
  output logic                              conv_busy,
  output logic                              result_meaningless,
  output logic      [amsc_pkg::RES_W-1:0]   result_word
);
  import amsc_pkg::*;

  logic [DS_W-1:0]   s;
  logic [DS_W-1:0]   prev;
  amsc_conv_t        st, next_st;
  logic [CNT_W-1:0]  cnt, next_cnt;
  logic [CHAN_W-1:0] chan_latch, next_chan_latch;
  logic [CHAN_W-1:0] addr_out, next_addr_out;
  logic              chan_rst, next_chan_rst;
  logic [CHAN_W-1:0] next_conv_chan;
  logic              next_conv_busy;
  logic              next_bad;
  logic [RES_W-1:0]  conv_word, next_conv_word;
  logic [RES_W-1:0]  next_result_word;
  logic [RES_W-1:0]  sh, next_sh;
  logic              sdo, next_sdo;
  logic              sdo_oe, next_sdo_oe;
  logic              busy_n, next_busy_n;
  logic [PH_W-1:0]   ip, next_ip;
  logic [BIT_W-1:0]  ibits, next_ibits;
  logic              iclk, next_iclk;
  logic              tag_hold, next_tag_hold;
  logic [1:0]        a_oe, next_a_oe;
  logic              start, done, edge_start, auto_start;
  logic              pd_fall, cm_rise, dk_rise, rd_en, int_en, int_evt;

  amsc_sync #(.W(DS_W)) u_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .d       ({lnk.chan_addr_bit1, lnk.chan_addr_bit0, lnk.daisy_in, lnk.data_shift_clock,
               lnk.ext_clock_select, lnk.continuous_mode_select, lnk.power_down,
               lnk.rd_conv, lnk.cs_n}),
    .q       (s)
  );

  assign lnk.busy_n         = busy_n;
  assign lnk.int_data_clock = iclk;
  assign lnk.serial_out_drv = sdo;
  assign lnk.serial_out_oe  = sdo_oe;
  assign lnk.dev_addr_out   = addr_out;
  assign lnk.dev_addr_oe    = a_oe;

  ////////////////////////////////////////////////////////////////////////////
  // Edge decode on synchronised pins
  always_comb begin
    pd_fall    = prev[DS_PD] & ~s[DS_PD];
    cm_rise    = ~prev[DS_CM] & s[DS_CM];
    dk_rise    = ~prev[DS_DK] & s[DS_DK];
    rd_en      = ~s[DS_CS] & s[DS_RC];
    edge_start = (~s[DS_CS] & prev[DS_RC] & ~s[DS_RC])
               | (prev[DS_CS] & ~s[DS_CS] & ~s[DS_RC]);
    auto_start = s[DS_CM] & ~s[DS_CS] & ~s[DS_RC] & ~s[DS_PD];
    start      = (st == CV_IDLE) & (edge_start | auto_start);
    done       = (st == CV_RUN) & (cnt == CONV_CYC - CNT_W'(1));
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion timer, busy and result capture
  always_comb begin
    next_st            = st;
    next_cnt           = cnt;
    next_busy_n        = busy_n;
    next_conv_busy     = conv_busy;
    next_conv_chan     = conv_chan;
    next_conv_word     = conv_word;
    next_result_word   = result_word;
    next_bad           = result_meaningless;
    unique case (st)
      CV_IDLE: begin
        if (start) begin
          next_st        = CV_RUN;
          next_cnt       = '0;
          next_busy_n    = 1'b0;
          next_conv_busy = 1'b1;
          next_conv_word = sample_value;
          next_bad       = s[DS_PD];
          // Next address, so mode entry converts latch plus one, or zero after a channel reset, at once
          next_conv_chan = s[DS_CM] ? next_addr_out : chan_latch;
        end
      end
      CV_RUN: begin
        next_cnt = cnt + CNT_W'(1);
        if (s[DS_PD]) begin
          next_bad = 1'b1;
        end
        if (done) begin
          next_st          = CV_IDLE;
          next_busy_n      = 1'b1;
          next_conv_busy   = 1'b0;
          next_result_word = conv_word;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st                 <= CV_IDLE;
      cnt                <= '0;
      busy_n             <= 1'b1;
      conv_busy          <= 1'b0;
      conv_chan          <= CHAN_ZERO;
      conv_word          <= '0;
      result_word        <= '0;
      result_meaningless <= 1'b0;
      prev               <= '0;
    end else begin
      st                 <= next_st;
      cnt                <= next_cnt;
      busy_n             <= next_busy_n;
      conv_busy          <= next_conv_busy;
      conv_chan          <= next_conv_chan;
      conv_word          <= next_conv_word;
      result_word        <= next_result_word;
      result_meaningless <= next_bad;
      prev               <= s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel latch and continuous sequencer
  always_comb begin
    next_chan_latch = chan_latch;
    next_chan_rst   = chan_rst;
    next_addr_out   = addr_out;
    next_a_oe       = {2{s[DS_CM]}};
    if (start & ~s[DS_CM]) begin
      next_chan_latch = {s[DS_A1], s[DS_A0]};
      next_chan_rst   = 1'b0;
    end else if (pd_fall) begin
      next_chan_latch = CHAN_ZERO;
      next_chan_rst   = 1'b1;
    end
    if (s[DS_CM] & s[DS_PD]) begin
      next_addr_out = CHAN_ZERO;
    end else if (pd_fall) begin
      next_addr_out = CHAN_ZERO;
    end else if (cm_rise) begin
      next_addr_out = chan_rst ? CHAN_ZERO : chan_latch + CHAN_STEP;
    end else if (done & s[DS_CM]) begin
      next_addr_out = (addr_out == CHAN_LAST) ? CHAN_ZERO : addr_out + CHAN_STEP;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      chan_latch <= CHAN_ZERO;
      chan_rst   <= 1'b1;
      addr_out   <= CHAN_ZERO;
      a_oe       <= 2'h0;
    end else begin
      chan_latch <= next_chan_latch;
      chan_rst   <= next_chan_rst;
      addr_out   <= next_addr_out;
      a_oe       <= next_a_oe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial output: external shift or internal clocked burst
  // With the external clock, reload only at busy rise keeps the old word well past 12 us after start; the internal clock reloads at start.
  always_comb begin
    int_en        = ~s[DS_EX] & (st == CV_RUN) & (cnt >= INT_DLY_CYC);
    int_evt       = int_en & (ip == '0) & (ibits != BITS_STOP);
    next_sh       = sh;
    next_sdo      = sdo;
    next_ip       = ip;
    next_ibits    = ibits;
    next_iclk     = 1'b0;
    next_tag_hold = tag_hold;
    next_sdo_oe   = s[DS_EX] ? rd_en : (st == CV_RUN);
    if (start) begin
      next_ip    = '0;
      next_ibits = '0;
      if (!s[DS_EX]) begin
        next_sh = sample_value;
      end
    end else if (int_en) begin
      next_ip   = (ip == INT_PER_CYC - PH_W'(1)) ? '0 : ip + PH_W'(1);
      next_iclk = (ibits < BITS_DONE) & (ip < INT_HALF);
    end
    if (done) begin
      next_sh = conv_word;
    end else if (int_evt) begin
      next_ibits = ibits + BIT_W'(1);
      if (ibits == '0) begin
        next_tag_hold = s[DS_TG];
      end
      if (ibits == BITS_DONE) begin
        next_sdo = tag_hold;
      end else begin
        next_sdo = sh[RES_W-1];
        next_sh  = {sh[RES_W-2:0], 1'b0};
      end
    end else if (s[DS_EX] & rd_en & dk_rise) begin
      next_sdo = sh[RES_W-1];
      next_sh  = {sh[RES_W-2:0], s[DS_TG]};
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sh       <= '0;
      sdo      <= 1'b0;
      sdo_oe   <= 1'b0;
      ip       <= '0;
      ibits    <= '0;
      iclk     <= 1'b0;
      tag_hold <= 1'b0;
    end else begin
      sh       <= next_sh;
      sdo      <= next_sdo;
      sdo_oe   <= next_sdo_oe;
      ip       <= next_ip;
      ibits    <= next_ibits;
      iclk     <= next_iclk;
      tag_hold <= next_tag_hold;
    end
  end
endmodule // amsc_dev_end

// ==== hw/amsc_host_end.sv ====
// Host end: drives control pins, clocks out results, paces power-down.
// Assumes the converter end on the far side of the same link interface.
`timescale 1ns/10ps
module amsc_host_end #(
  parameter int SETTLE = amsc_pkg::SETTLE_CYC
) (
  input  wire logic                         clk,
  input  wire logic                         reset_n,
  amsc_link_if.host                         lnk,
  input  wire logic                         conv_req,
  input  wire logic                         read_req,
  input  wire logic                         pd_req,
  input  wire logic                         cont_req,
  input  wire logic [amsc_pkg::CHAN_W-1:0]  chan_sel,
  input  wire logic                         tag_value,
  output logic                              host_ready,
  output logic                              rd_valid,
  output logic      [amsc_pkg::RES_W-1:0]   rd_word,
  output logic      [amsc_pkg::CHAN_W-1:0]  chan_seen
);
  import amsc_pkg::*;

  logic [3:0]        s;
  amsc_host_t        st, next_st;
  logic [PH_W-1:0]   cnt, next_cnt;
  logic [BIT_W-1:0]  bits, next_bits;
  logic [SET_W-1:0]  settle, next_settle;
  logic              rc, next_rc;
  logic              pd, next_pd;
  logic              dk, next_dk;
  logic              cm, next_cm;
  logic [CHAN_W-1:0] aout, next_aout;
  logic              next_rd_valid;
  logic [RES_W-1:0]  next_rd_word;

  amsc_sync #(.W(4)) u_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .d       ({lnk.chan_addr_bit1, lnk.chan_addr_bit0, lnk.serial_out, lnk.busy_n}),
    .q       (s)
  );

  assign lnk.cs_n                   = 1'b0;
  assign lnk.ext_clock_select       = 1'b1;
  assign lnk.rd_conv                = rc;
  assign lnk.power_down             = pd;
  assign lnk.data_shift_clock       = dk;
  assign lnk.continuous_mode_select = cm;
  assign lnk.daisy_in               = tag_value;
  assign lnk.host_addr_out          = aout;
  assign lnk.host_addr_oe           = {2{~cm}};

  ////////////////////////////////////////////////////////////////////////////
  // Host sequencer; reads only after busy rise, never mid-conversion
  always_comb begin
    next_st       = st;
    next_cnt      = cnt;
    next_bits     = bits;
    next_rc       = rc;
    next_pd       = pd;
    next_dk       = 1'b0;
    next_rd_valid = 1'b0;
    next_rd_word  = rd_word;
    next_aout     = chan_sel;
    next_settle   = (settle != '0) ? settle - SET_W'(1) : settle;
    // Mode held through a power-down pulse so it can reset the sequence
    next_cm       = cont_req & (settle == '0) & ((st == H_IDLE) | (st == H_PD));
    unique case (st)
      H_IDLE: begin
        next_rc = ~next_cm; // Low only with the mode, never a stray manual start
        if (pd_req) begin
          next_st  = H_PD;
          next_cnt = '0;
          next_pd  = 1'b1;
        end else if (conv_req & ~cm) begin
          next_st  = H_CONV;
          next_cnt = '0;
          next_rc  = 1'b0;
        end else if (read_req & ~cm & s[0]) begin
          next_st   = H_READ;
          next_cnt  = '0;
          next_bits = '0;
        end
      end
      H_CONV: begin
        next_cnt = cnt + PH_W'(1);
        if (cnt == RC_LOW_CYC - PH_W'(1)) begin
          next_rc = 1'b1;
          next_st = H_WAITLO;
        end
      end
      H_WAITLO: begin
        if (!s[0]) begin
          next_st = H_WAITHI;
        end
      end
      H_WAITHI: begin
        if (s[0]) begin
          next_st = H_IDLE;
        end
      end
      H_READ: begin
        next_cnt = (cnt == EXT_PER_CYC - PH_W'(1)) ? '0 : cnt + PH_W'(1);
        next_dk  = (next_cnt < EXT_HALF) & (bits != BITS_DONE);
        if (cnt == EXT_PER_CYC - PH_W'(1)) begin
          next_rd_word = {rd_word[RES_W-2:0], s[1]};
          next_bits    = bits + BIT_W'(1);
          if (bits == BITS_DONE - BIT_W'(1)) begin
            next_rd_valid = 1'b1;
            next_st       = H_IDLE;
            next_dk       = 1'b0;
          end
        end
      end
      H_PD: begin
        next_cnt = cnt + PH_W'(1);
        if (cnt == PD_CYC - PH_W'(1)) begin
          next_pd     = 1'b0;
          next_st     = H_IDLE;
          next_settle = SET_W'(SETTLE);
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st         <= H_IDLE;
      cnt        <= '0;
      bits       <= '0;
      settle     <= '0;
      rc         <= 1'b1;
      pd         <= 1'b0;
      dk         <= 1'b0;
      cm         <= 1'b0;
      aout       <= CHAN_ZERO;
      rd_valid   <= 1'b0;
      rd_word    <= '0;
      host_ready <= 1'b0;
      chan_seen  <= CHAN_ZERO;
    end else begin
      st         <= next_st;
      cnt        <= next_cnt;
      bits       <= next_bits;
      settle     <= next_settle;
      rc         <= next_rc;
      pd         <= next_pd;
      dk         <= next_dk;
      cm         <= next_cm;
      aout       <= next_aout;
      rd_valid   <= next_rd_valid;
      rd_word    <= next_rd_word;
      host_ready <= (next_st == H_IDLE);
      chan_seen  <= s[3:2];
    end
  end
endmodule // amsc_host_end

// ==== dv/amsc_link_chk.sv ====
// Pin-level checks on the link joining the converter end and the host end.
// Assumes both ends share one clock domain and its synchronous reset.
`timescale 1ns/10ps
module amsc_link_chk
  import amsc_pkg::*;
(
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic       cs_n,
  input wire logic       rd_conv,
  input wire logic       power_down,
  input wire logic       continuous_mode_select,
  input wire logic       busy_n,
  input wire logic [1:0] dev_addr_out,
  input wire logic [1:0] dev_addr_oe
);
  logic [CNT_W-1:0] lo_cnt;
  logic [CNT_W-1:0] next_lo_cnt;

  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  ////////////////////////////////////////////////////////////////////////////
  // Busy-low stretch length; cleared while busy is high
  always_comb begin
    next_lo_cnt = busy_n ? '0 : lo_cnt + 1'b1;
  end

  always_ff @(posedge clk) begin
    lo_cnt <= reset_n ? next_lo_cnt : '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  a_busy_len_exact: assert property ($rose(busy_n) |-> lo_cnt == CONV_CYC)
    else $error("busy low stretch differs from conversion time");
  a_busy_len_max: assert property (lo_cnt <= CONV_CYC)
    else $error("busy low stretch too long");
  a_start_busy: assert property ($fell(rd_conv) && !cs_n && busy_n |-> ##[2:6] !busy_n)
    else $error("start edge did not lower busy");
  a_cont_restart: assert property ($rose(busy_n) && continuous_mode_select && $past(continuous_mode_select, 4)
    && !cs_n && !rd_conv && !power_down |-> ##[1:6] !busy_n)
    else $error("continuous mode did not restart");
  // Drive only judged once mode has settled through the synchronisers
  a_cont_oe: assert property (continuous_mode_select [*8] |-> dev_addr_oe == 2'h3)
    else $error("address pins not driven in continuous mode");
  a_man_oe: assert property ((!continuous_mode_select && busy_n) [*8] |-> dev_addr_oe == 2'h0)
    else $error("address pins driven in manual mode");
  a_addr_step: assert property ($rose(busy_n) && dev_addr_oe == 2'h3 && $past(dev_addr_oe) == 2'h3
    && !power_down && !$past(power_down, 4) |-> dev_addr_out == 2'($past(dev_addr_out) + 2'h1))
    else $error("address did not step at busy rise");
  a_addr_hold: assert property (!busy_n && !$past(busy_n) && dev_addr_oe == 2'h3 && !power_down
    && !$past(power_down, 4) |-> $stable(dev_addr_out))
    else $error("address moved during conversion");
  a_pd_zero: assert property ((continuous_mode_select && power_down) [*8]
    |-> (dev_addr_oe != 2'h3 || dev_addr_out == 2'h0))
    else $error("power-down did not select channel zero");
endmodule // amsc_link_chk

// ==== dv/adc_mux_sequencer_control_bench.sv ====
// Bench joining both link ends, with a channel-order and result model.
// Assumes the package, link interface and both ends are compiled first.
`timescale 1ns/10ps
module adc_mux_sequencer_control_bench;
  import amsc_pkg::*;
  logic              clk;
  logic              reset_n;
  logic [RES_W-1:0]  sample_value;
  logic [CHAN_W-1:0] conv_chan;
  logic              conv_busy;
  logic              result_meaningless;
  logic [RES_W-1:0]  result_word;
  logic              conv_req;
  logic              read_req;
  logic              pd_req;
  logic              cont_req;
  logic [CHAN_W-1:0] chan_sel;
  logic              tag_value;
  logic              host_ready;
  logic              rd_valid;
  logic [RES_W-1:0]  rd_word;
  logic [CHAN_W-1:0] chan_seen;
  logic [RES_W-1:0]  smp;
  logic [CHAN_W-1:0] ch;
  int                n_fail;
  int                check_count;
  int                seed;
  int                exp_chan;
  int                lat_q[$];

  amsc_link_if lnk ();

  amsc_dev_end u_amsc_dev_end (
    .clk                (clk),
    .reset_n            (reset_n),
    .lnk                (lnk),
    .sample_value       (sample_value),
    .conv_chan          (conv_chan),
    .conv_busy          (conv_busy),
    .result_meaningless (result_meaningless),
    .result_word        (result_word)
  );

  // Short settle keeps continuous entry quick in simulation
  amsc_host_end #(.SETTLE(100)) u_amsc_host_end (
    .clk        (clk),
    .reset_n    (reset_n),
    .lnk        (lnk),
    .conv_req   (conv_req),
    .read_req   (read_req),
    .pd_req     (pd_req),
    .cont_req   (cont_req),
    .chan_sel   (chan_sel),
    .tag_value  (tag_value),
    .host_ready (host_ready),
    .rd_valid   (rd_valid),
    .rd_word    (rd_word),
    .chan_seen  (chan_seen)
  );

  amsc_link_chk u_amsc_link_chk (
    .clk                    (clk),
    .reset_n                (reset_n),
    .cs_n                   (lnk.cs_n),
    .rd_conv                (lnk.rd_conv),
    .power_down             (lnk.power_down),
    .continuous_mode_select (lnk.continuous_mode_select),
    .busy_n                 (lnk.busy_n),
    .dev_addr_out           (lnk.dev_addr_out),
    .dev_addr_oe            (lnk.dev_addr_oe)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic check(input string what, input logic [RES_W-1:0] seen, input logic [RES_W-1:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Bounded wait: 0 busy, 1 host ready, 2 read valid
  task automatic wait_on(input int w, input logic lvl);
    logic cur;
    for (int n = 0; n < 8000; n++) begin
      cur = (w == 0) ? conv_busy : (w == 1) ? host_ready : rd_valid;
      if (cur === lvl) break;
      @(negedge clk);
    end
    check("wait", cur, lvl);
  endtask

  // Host request pulse: 0 convert, 1 read, 2 power-down
  task automatic req(input int k);
    wait_on(1, 1'b1);
    conv_req = (k == 0);
    read_req = (k == 1);
    pd_req   = (k == 2);
    @(negedge clk);
    conv_req = 1'b0;
    read_req = 1'b0;
    pd_req   = 1'b0;
  endtask

  // Manual conversion; sample changed after start proves capture at start
  task automatic conv(input logic [1:0] c, input logic chk);
    int exp;
    chan_sel = c;
    smp = 12'($random(seed));
    sample_value = smp;
    tag_value = 1'($random(seed));
    repeat (6) @(negedge clk);
    check("addr pins", {lnk.chan_addr_bit1, lnk.chan_addr_bit0}, c);
    check("chan seen", chan_seen, c);
    lat_q.push_back(c);
    req(0);
    wait_on(0, 1'b1);
    exp = lat_q.pop_front();
    if (chk) check("conv chan", conv_chan, exp[1:0]);
    if (!chk) lat_q.delete();
    if (!chk) lat_q.push_back(c);
    sample_value = ~smp;
    wait_on(0, 1'b0);
    check("result", result_word, smp);
    check("meaningless", result_meaningless, 1'b0);
  endtask

  task automatic rd();
    req(1);
    wait_on(2, 1'b1);
    check("read word", rd_word, smp);
  endtask

  // Continuous run from a given first channel, then back to manual
  task automatic cont(input int first, input int n);
    exp_chan = first;
    cont_req = 1'b1;
    for (int k = 0; k < n; k++) begin
      wait_on(0, 1'b1);
      check("cont chan", conv_chan, exp_chan[1:0]);
      exp_chan = (exp_chan + 1) % 4;
      wait_on(0, 1'b0);
      repeat (6) @(negedge clk);
      check("cont pins", {lnk.chan_addr_bit1, lnk.chan_addr_bit0}, exp_chan[1:0]);
      check("cont seen", chan_seen, exp_chan[1:0]);
    end
    cont_req = 1'b0;
    wait_on(0, 1'b0);
    repeat (20) @(negedge clk);
    check("stopped", conv_busy, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    seed = 32'h237d;
    n_fail = 0;
    check_count = 0;
    sample_value = '0;
    conv_req = 1'b0;
    read_req = 1'b0;
    pd_req = 1'b0;
    cont_req = 1'b0;
    chan_sel = 2'h0;
    tag_value = 1'b0;
    reset_n = 1'b0;
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    for (int i = 0; i < 6; i++) begin
      ch = (i == 5) ? 2'h1 : 2'($random(seed));
      conv(ch, i != 0);
      if (i % 2 == 1) rd();
    end
    cont(2, 4);
    // Power-down inside continuous mode: channel zero out, result flagged
    cont_req = 1'b1;
    wait_on(0, 1'b1);
    check("entry chan", conv_chan, 2'h2);
    req(2);
    repeat (20) @(negedge clk);
    check("pd pins", {lnk.chan_addr_bit1, lnk.chan_addr_bit0}, 2'h0);
    cont_req = 1'b0;
    wait_on(0, 1'b0);
    check("pd result", result_meaningless, 1'b1);
    cont(0, 2);
    conv(2'h3, 1'b0);
    rd();
    results();
  end

  // Watchdog well beyond the expected run length
  initial begin
    #400000;
    n_fail++;
    results();
  end
endmodule // adc_mux_sequencer_control_bench
